// ### rtl/sas_top.sv
`timescale 1ns/100ps
// Behaviour
// - Writing start bit one begins conversion.
// - Software start ignores external trigger enable.
// - Enabled rising start pin edge begins conversion.
// - Pin edge seen at cycle end.
// - Software start begins next machine cycle.
// - Start bit: command flop, status flop.
// - Status set after first init cycle.
// - Sampling begins after second init cycle.
// - Sampling lasts eight machine cycles.
// - First trial sets top bit only.
// - Next lower bits tried until ten done.
// - Each bit trial takes four cycles.
// - Completion flag set after conversion.
// - Upper eight bits high, two low control.
// - Done sets and status clears 52 cycles later.
// - Control bits one, zero select channel.
// - Starts ignored while converting.
// - Result frozen while completion flag set.
// - Idle or power-down aborts conversion.
module sas_top
  import sas_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_start_pin,
  input wire logic cmp_above,
  output logic [1:0] mux_sel,
  output logic [9:0] sar_code,
  output logic sample_hold,
  output logic conv_busy
);

  // ===========================================================
  // Bus slave
  sas_ahb_ap_t ap_q;
  sas_ahb_ap_t ap_d;
  logic [31:0] rdata_d;
  logic wr_ctrl, wr_lpwr, clr_done_wr, sw_start_wr, abort;

  sas_state_t st_q;
  logic [1:0] phase_q;
  logic [5:0] mc_q;
  logic [1:0] sub_q;
  logic [3:0] bit_q;
  logic [9:0] sar_q;
  logic [9:0] res_q;
  logic cmd_q;
  logic status_q;
  logic done_q;
  logic exten_q;
  logic [1:0] lpwr_q;
  logic ext_s1_q, ext_s2_q, ext_prev_q, cmp_s1_q, cmp_s2_q;
  logic mc_end, ext_rise, launch, finish;

  always_comb begin
    ap_d.valid = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    ap_d.write = hwrite;
    ap_d.addr = haddr[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else begin
      ap_q <= ap_d;
    end
  end

  // Read data is latched in the address phase so that it leaves a flop.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ap_d.addr)
      OFS_CTRL: begin
        rdata_d[CTRL_LSB0 +: 2] = res_q[1:0];
        rdata_d[CTRL_EXTEN] = exten_q;
        rdata_d[CTRL_DONE] = done_q;
        rdata_d[CTRL_START] = status_q;
        rdata_d[1:0] = mux_sel;
      end
      OFS_RESH: rdata_d[7:0] = res_q[9:2];
      OFS_LPWR: rdata_d[1:0] = lpwr_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_d.valid && !ap_d.write) begin
        hrdata <= rdata_d;
      end
    end
  end

  assign wr_ctrl = ap_q.valid & ap_q.write & (ap_q.addr == OFS_CTRL);
  assign wr_lpwr = ap_q.valid & ap_q.write & (ap_q.addr == OFS_LPWR);
  assign clr_done_wr = wr_ctrl & ~hwdata[CTRL_DONE];
  assign sw_start_wr = wr_ctrl & hwdata[CTRL_START] & (st_q == ST_IDLE);
  assign abort = wr_lpwr & ((hwdata[1:0] & ~lpwr_q) != 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exten_q <= 1'b0;
      mux_sel <= SEL_RESET;
    end else if (wr_ctrl) begin
      exten_q <= hwdata[CTRL_EXTEN];
      mux_sel <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpwr_q <= 2'h0;
    end else if (wr_lpwr) begin
      lpwr_q <= hwdata[1:0];
    end
  end

  // ===========================================================
  // Machine cycle timing and input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign mc_end = (phase_q == PH_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_start_pin;
      ext_s2_q <= ext_s1_q;
      cmp_s1_q <= cmp_above;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_q <= 1'b0;
    end else if (mc_end) begin
      ext_prev_q <= ext_s2_q;
    end
  end

  // A pulse shorter than one machine cycle may fall between two samples.
  // Enabled pin edge
  assign ext_rise = mc_end & exten_q & ext_s2_q & ~ext_prev_q;
  assign launch = mc_end & (st_q == ST_IDLE) & (cmd_q | ext_rise)
                & (lpwr_q == 2'h0) & ~abort;
  assign finish = mc_end & (st_q == ST_HOLD) & (mc_q == MC_DONE) & ~abort;

  // ===========================================================
  // Start command flop
  // Command flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 1'b0;
    end else if (launch || abort) begin
      cmd_q <= 1'b0;
    end else if (sw_start_wr) begin
      cmd_q <= 1'b1;
    end
  end

  // ===========================================================
  // Conversion sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      mc_q <= 6'h00;
      sub_q <= 2'h0;
      bit_q <= BIT_TOP;
      sar_q <= 10'h000;
      sample_hold <= 1'b0;
    end else if (abort) begin
      st_q <= ST_IDLE;
      sample_hold <= 1'b0;
    end else if (mc_end) begin
      case (st_q)
        ST_IDLE: begin
          if (launch) begin
            st_q <= ST_INIT;
            mc_q <= 6'h00;
          end
        end
        ST_INIT: begin
          mc_q <= mc_q + 6'h01;
          if (mc_q == MC_INIT_LAST) begin
            st_q <= ST_SAMPLE;
            sample_hold <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          mc_q <= mc_q + 6'h01;
          if (mc_q == MC_SAMPLE_LAST) begin
            st_q <= ST_TRIAL;
            sample_hold <= 1'b0;
            sar_q <= SAR_FIRST;
            bit_q <= BIT_TOP;
            sub_q <= 2'h0;
          end
        end
        ST_TRIAL: begin
          mc_q <= mc_q + 6'h01;
          sub_q <= sub_q + 2'h1;
          if (sub_q == TRIAL_LAST) begin
            sar_q[bit_q] <= cmp_s2_q;
            if (bit_q == 4'h0) begin
              st_q <= ST_HOLD;
            end else begin
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        ST_HOLD: begin
          mc_q <= mc_q + 6'h01;
          if (mc_q == MC_DONE) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 1'b0;
    end else if (abort || finish) begin
      status_q <= 1'b0;
    end else if (mc_end && st_q == ST_INIT && mc_q == MC_STATUS) begin
      status_q <= 1'b1;
    end
  end

  // A set in the same cycle as a software clear wins over the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (clr_done_wr) begin
      done_q <= 1'b0;
    end
  end

  // A result not yet taken by software is kept; a later one is dropped.
  // Frozen while done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 10'h000;
    end else if (finish && !done_q) begin
      res_q <= sar_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_code <= 10'h000;
      conv_busy <= 1'b0;
    end else begin
      sar_code <= sar_q;
      conv_busy <= (st_q != ST_IDLE);
    end
  end

  // ===========================================================
  // Assertions
  logic [8:0] stat_cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_cnt_q <= 9'h000;
    end else if (status_q) begin
      stat_cnt_q <= stat_cnt_q + 9'h001;
    end else begin
      stat_cnt_q <= 9'h000;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A low-power abort cuts sampling short, so such attempts are dropped.
  sequence s_hold16;
    sample_hold [*8] ##1 sample_hold [*8];
  endsequence

  sequence s_sample_window;
    s_hold16 ##1 s_hold16 ##1 !sample_hold;
  endsequence

  property p_sw_start;
    sw_start_wr && lpwr_q == 2'h0 && !abort |-> ##[2:5] st_q == ST_INIT;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start lost");

  property p_ext_start;
    ext_rise && st_q == ST_IDLE && lpwr_q == 2'h0 && !abort |=> st_q == ST_INIT;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("pin start lost");

  property p_status_rise;
    $rose(status_q) |-> st_q == ST_INIT && mc_q == MC_INIT_LAST && phase_q == 2'h0;
  endproperty
  a_status_rise: assert property (p_status_rise) else $error("status set late");

  property p_sample_start;
    $rose(sample_hold) |-> mc_q == 6'h02 && st_q == ST_SAMPLE;
  endproperty
  a_sample_start: assert property (p_sample_start) else $error("sampling misplaced");

  property p_sample_len;
    disable iff (!hresetn || lpwr_q != 2'h0) $rose(sample_hold) |-> s_sample_window;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong");

  property p_first_trial;
    $fell(sample_hold) && st_q == ST_TRIAL |-> sar_q == SAR_FIRST;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial wrong");

  property p_conv_time;
    $fell(status_q) && $past(finish) |-> stat_cnt_q == 9'(CONV_CLKS);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

  property p_busy_ignore;
    st_q != ST_IDLE && wr_ctrl && hwdata[CTRL_START] |=> !cmd_q;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy");

  property p_result_hold;
    done_q && $past(done_q) |-> res_q == $past(res_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed");

  property p_abort;
    abort |=> st_q == ST_IDLE && !status_q ##1 !conv_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");

  property p_done_clear;
    $fell(done_q) |-> $past(clr_done_wr);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done cleared by hardware");

  property p_result_store;
    $rose(done_q) |-> res_q == $past(sar_q);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored");

endmodule

// ### rtl/sas_pkg.sv
package sas_pkg;

  // ===========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESH = 8'h04;
  localparam logic [7:0] OFS_LPWR = 8'h08;

  // ===========================================================
  // Control register fields
  localparam int CTRL_LSB0 = 6;
  localparam int CTRL_EXTEN = 5;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_START = 3;
  localparam int LPWR_IDLE = 0;
  localparam int LPWR_PDOWN = 1;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ===========================================================
  // Timing in machine cycles
  localparam int MC_CLKS = 4;
  localparam logic [1:0] PH_LAST = 2'(MC_CLKS - 1);
  localparam logic [5:0] MC_STATUS = 6'h00;
  localparam logic [5:0] MC_INIT_LAST = 6'h01;
  localparam logic [5:0] MC_SAMPLE_LAST = 6'h09;
  localparam logic [5:0] MC_DONE = 6'h34;
  localparam logic [1:0] TRIAL_LAST = 2'h3;
  localparam logic [3:0] BIT_TOP = 4'h9;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam int CONV_CLKS = 52 * MC_CLKS;
  localparam int SAMPLE_CLKS = 8 * MC_CLKS;

  // ===========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INIT,
    ST_SAMPLE,
    ST_TRIAL,
    ST_HOLD
  } sas_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } sas_ahb_ap_t;

endpackage

// ### dv/sas_analog_model.sv
`timescale 1ns/100ps
// ============================================================
// Ladder and comparator seen from the sequencer
module sas_analog_model (
  input wire logic [9:0] vin,
  input wire logic [9:0] sar_code,
  output logic cmp_above
);
  // keep or clear.
  // The comparator has no hysteresis, so a tie reads as not above.
  assign cmp_above = (vin > sar_code);
endmodule

// ### dv/test_sar_adc_sequencer.sv
`timescale 1ns/100ps
module test_sar_adc_sequencer;
  import sas_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_start_pin = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [9:0] vin = 10'h000;
  logic [9:0] last = 10'h000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cmp_above, sample_hold, conv_busy;
  logic [1:0] mux_sel;
  logic [9:0] sar_code;
  logic [31:0] d;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h44f20569;

  // ============================================================
  // Clock and instances
  always #20 hclk = ~hclk;

  sas_top sas_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_start_pin(ext_start_pin),
    .cmp_above(cmp_above), .mux_sel(mux_sel), .sar_code(sar_code),
    .sample_hold(sample_hold), .conv_busy(conv_busy));

  sas_analog_model sas_analog_model_i (.vin(vin), .sar_code(sar_code),
    .cmp_above(cmp_above));

  // ============================================================
  // Checking and ending
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    fails++;
    $display("BAD wait %s expected done seen hang", what);
    give_verdict();
  endtask

  function automatic logic [9:0] exp_code(input logic [9:0] v);
    logic [9:0] r;
    r = 10'h000;
    for (int b = 9; b >= 0; b--) begin
      if (v > (r | (10'h001 << b))) begin
        r = r | (10'h001 << b);
      end
    end
    return r;
  endfunction

  // ============================================================
  // Bus master
  task automatic wait_rdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) timeout("hready");
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, a, wd, x);
  endtask

  task automatic wait_sig(input logic exp, input logic hold, input int bound);
    int n = 0;
    while ((hold ? sample_hold : conv_busy) !== exp) begin
      n++;
      if (n > bound) timeout("sequencer");
      @(posedge hclk);
    end
  endtask

  // ============================================================
  // One conversion with timing and result checks
  task automatic run_conv(input logic [9:0] v, input logic [1:0] s, input logic keep);
    logic [31:0] c;
    int n = 0;
    c = 32'h0000_0008 | (32'(keep) << CTRL_DONE) | 32'(s);
    vin <= v;
    wr(OFS_CTRL, c);
    wait_sig(1'b1, 1'b0, 8);
    wait_sig(1'b1, 1'b1, 12);
    while (sample_hold === 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    check("sample width", 32'(n), 32'(SAMPLE_CLKS));
    ahb(1'b0, OFS_CTRL, 32'h0, d);
    check("status busy", 32'(d[CTRL_START]), 32'h1);
    wr(OFS_CTRL, c);
    repeat (163) @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0, d);
    check("done early", 32'(d[CTRL_DONE]), 32'(keep));
    check("status late", 32'(d[CTRL_START]), 32'h1);
    repeat (6) @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0, d);
    check("done set", 32'(d[CTRL_DONE]), 32'h1);
    check("status clear", 32'(d[CTRL_START]), 32'h0);
    if (!keep) last = exp_code(v);
    check("result low", 32'(d[7:6]), 32'(last[1:0]));
    check("select bits", 32'(d[1:0]), 32'(s));
    check("mux select", 32'(mux_sel), 32'(s));
    ahb(1'b0, OFS_RESH, 32'h0, d);
    check("result high", d, 32'(last[9:2]));
  endtask

  task automatic pulse_pin;
    // symmetric pulse of three machine cycles.
    ext_start_pin <= 1'b1;
    repeat (12) @(posedge hclk);
    ext_start_pin <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CTRL, 32'h0, d);
    check("ctrl reset", d, 32'h0);
    ahb(1'b0, 8'h0C, 32'h0, d);
    check("unmapped", d, 32'h0);
    run_conv(10'h000, 2'h3, 1'b0);
    run_conv(10'h3FF, 2'h2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run_conv(10'($random(seed)), 2'($random(seed)), 1'b0);
    end
    run_conv(10'($random(seed)), 2'h1, 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
    pulse_pin();
    check("pin disabled", 32'(conv_busy), 32'h0);
    vin <= 10'h155;
    wr(OFS_CTRL, 32'h0000_0020);
    pulse_pin();
    wait_sig(1'b1, 1'b0, 24);
    wait_sig(1'b0, 1'b0, 260);
    ahb(1'b0, OFS_RESH, 32'h0, d);
    last = exp_code(10'h155);
    check("pin result", d, 32'(last[9:2]));
    for (int lp = 1; lp < 3; lp++) begin
      wr(OFS_CTRL, 32'h0000_0008);
      wait_sig(1'b1, 1'b0, 8);
      repeat (20) @(posedge hclk);
      wr(OFS_LPWR, 32'(lp));
      wait_sig(1'b0, 1'b0, 4);
      ahb(1'b0, OFS_CTRL, 32'h0, d);
      check("abort flags", 32'(d[CTRL_DONE:CTRL_START]), 32'h0);
      ahb(1'b0, OFS_RESH, 32'h0, d);
      check("abort result", d, 32'(last[9:2]));
      wr(OFS_LPWR, 32'h0);
    end
    give_verdict();
  end
endmodule
